// ==== hw/tmr_pkg.sv ====
// constants shared by the 16-bit timer and its helper modules
package tmr_pkg;
	// register word indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL_A = 6'h00;
	localparam logic [5:0] IDX_CTRL_B = 6'h01;
	localparam logic [5:0] IDX_CNT_LO = 6'h02;
	localparam logic [5:0] IDX_CNT_HI = 6'h03;
	localparam logic [5:0] IDX_CMPA_LO = 6'h04;
	localparam logic [5:0] IDX_CMPA_HI = 6'h05;
	localparam logic [5:0] IDX_CMPB_LO = 6'h06;
	localparam logic [5:0] IDX_CMPB_HI = 6'h07;
	localparam logic [5:0] IDX_CAP_LO = 6'h08;
	localparam logic [5:0] IDX_CAP_HI = 6'h09;
	localparam logic [5:0] IDX_FLAG = 6'h0A;
	localparam logic [5:0] IDX_MASK = 6'h0B;
	// control A fields
	localparam int CA_WGM_LO = 0;
	localparam int CA_COM_B = 4;
	localparam int CA_COM_A = 6;
	// control B fields
	localparam int CB_CS = 0;
	localparam int CB_WGM_HI = 3;
	localparam int CB_CAP_SRC = 5;
	localparam int CB_CAP_EDGE = 6;
	localparam int CB_NOISE = 7;
	// flag and mask bit positions
	localparam int FL_OVF = 0;
	localparam int FL_CMP_A = 1;
	localparam int FL_CMP_B = 2;
	localparam int FL_CAP = 3;
	// reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_HOLD = 8'h00;
	localparam logic [3:0] RST_FLAG = 4'h0;
	localparam logic [3:0] RST_MASK = 4'h0;
	localparam logic [15:0] RST_WORD = 16'h0000;
	// counter limits
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	// clock select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	// prescaler width and noise canceller sample count
	localparam int PRE_W = 10;
	localparam int FILT_SAMPLES = 4;
endpackage

// ==== hw/tmr_sync.sv ====
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module tmr_sync
	import tmr_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic pin,
	output logic level
);
	// all state in one packed struct
	typedef struct packed {
		logic [2:0] stage;
		logic level;
	} tmr_sync_t;
	tmr_sync_t s;
	tmr_sync_t next_s;

	// stage[0] feeds only stage[1]; a change counts once stages 1 and 2 agree
	always_comb
	begin
		next_s = s;
		next_s.stage = {s.stage[1:0], pin};
		if (s.stage[1] == s.stage[2])
		begin
			next_s.level = s.stage[2];
		end
	end

	// register the state
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			s <= '0;
		else
			s <= next_s;
	end

	assign level = s.level;
endmodule // tmr_sync
`default_nettype wire

// ==== hw/tmr_filter.sv ====
// capture noise canceller: output follows only a level held for all samples
`timescale 1ns/1ps
`default_nettype none
module tmr_filter
	import tmr_pkg::*;
#(
	parameter int SAMPLES = FILT_SAMPLES
)
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic enable,
	input wire logic din,
	output logic dout
);
	// refuse a window the comparison cannot use
	if (SAMPLES < 2)
		$error("tmr_filter: SAMPLES must be at least 2");

	typedef struct packed {
		logic [SAMPLES-1:0] hist;
		logic held;
	} tmr_filt_t;
	tmr_filt_t s;
	tmr_filt_t next_s;

	// shift in samples; change the held level when the window is uniform
	always_comb
	begin
		next_s = s;
		next_s.hist = {s.hist[SAMPLES-2:0], din};
		if (&s.hist)
			next_s.held = 1'b1;
		else if (~|s.hist)
			next_s.held = 1'b0;
	end

	// register the state
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			s <= '0;
		else
			s <= next_s;
	end

	// bypassed when disabled, which costs the extra delay only when asked for
	assign dout = enable ? s.held : din;
endmodule // tmr_filter
`default_nettype wire

// ==== hw/tmr_timer16.sv ====
// 16-bit timer/counter with byte-wide register access over classic Wishbone
// Operation
// - count, compares, capture: 16 bits, byte accesses
// - one shared high-byte holding register
// - low-byte write loads low plus held high
// - low-byte read copies upper byte to holding
// - compare reads bypass the holding register
// - control registers: 8 bits, single access
// - clock select: prescaler or pin edge, or stop
// - compares match counter on each timer tick, setting flags
// - matches drive pulse-width or frequency outputs
// - qualified pin/comparator edge captures the count
// - bottom signalled at 0x0000
// - max signalled at 0xFFFF
// - top fixed by mode, compare A, or capture
// - compare A as top: no pwm on output A, buffered only in pwm modes
// - request flags, each gated by mask bit
// - upper count location reaches holding register
// - count write beats clear and count
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16
	import tmr_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [ADDR_W-1:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire logic EXT_COUNT_PIN,
	input wire logic CAPTURE_PIN,
	input wire logic COMPARATOR_IN,
	output logic COMPARE_OUT_A,
	output logic COMPARE_OUT_B,
	output logic AT_BOTTOM,
	output logic AT_MAX,
	output logic [3:0] IRQ_REQ
);
	// the decode needs the word index bits
	if (ADDR_W < 8)
		$error("tmr_timer16: ADDR_W must be at least 8");

	// whole block state
	typedef struct packed {
		logic [7:0] timer_control_a; // modes and output actions
		logic [7:0] timer_control_b; // clock select, capture setup
		logic [7:0] hold; // shared high byte
		logic [15:0] count_value; // the counter
		logic up; // count direction in dual-slope modes
		logic [1:0][15:0] cmp; // active compare values
		logic [1:0][15:0] cmp_buf; // software side of the double buffer
		logic [15:0] capture_value; // captured count or top
		logic [3:0] timer_flag_reg; // sticky requests
		logic [3:0] timer_mask_reg; // request gates
		logic [1:0] cout; // compare output pins
		logic [PRE_W-1:0] pre; // free-running prescaler
		logic ext_prev; // last count pin level
		logic cap_prev; // last capture trigger level
		logic ack; // bus answer
		logic [7:0] rdata; // read data
		logic bottom; // counter sits at zero
		logic max; // counter sits at all ones
	} tmr_state_t;
	tmr_state_t s;
	tmr_state_t next_s;

	// synchronised and filtered pins
	logic ext_lvl;
	logic cap_pin_lvl;
	logic cmp_in_lvl;
	logic cap_raw;
	logic cap_lvl;

	// count pin through three stages
	tmr_sync u_sync_ext (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.pin(EXT_COUNT_PIN),
		.level(ext_lvl)
	);

	// capture pin through three stages
	tmr_sync u_sync_cap (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.pin(CAPTURE_PIN),
		.level(cap_pin_lvl)
	);

	// comparator output through three stages
	tmr_sync u_sync_cmp (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.pin(COMPARATOR_IN),
		.level(cmp_in_lvl)
	);

	// source select before the filter, so a switch can itself trigger
	assign cap_raw = s.timer_control_b[CB_CAP_SRC] ? cmp_in_lvl : cap_pin_lvl;

	// optional noise canceller on the capture trigger
	tmr_filter #(
		.SAMPLES(FILT_SAMPLES)
	) u_filter (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.enable(s.timer_control_b[CB_NOISE]),
		.din(cap_raw),
		.dout(cap_lvl)
	);

	// mode decode
	logic [3:0] mode;
	logic dual;
	logic pwm;
	logic icr_top;
	logic ocra_top;
	logic [15:0] top;
	assign mode = {s.timer_control_b[CB_WGM_HI +: 2], s.timer_control_a[CA_WGM_LO +: 2]};
	assign dual = mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
	assign pwm = !(mode inside {4'h0, 4'h4, 4'hC, 4'hD});
	assign icr_top = mode inside {4'h8, 4'hA, 4'hC, 4'hE};
	assign ocra_top = mode inside {4'h4, 4'h9, 4'hB, 4'hF};

	// top limit by mode
	always_comb
	begin
		case (mode)
			4'h1, 4'h5: top = TOP_8BIT;
			4'h2, 4'h6: top = TOP_9BIT;
			4'h3, 4'h7: top = TOP_10BIT;
			4'h4, 4'h9, 4'hB, 4'hF: top = s.cmp[0];
			4'h8, 4'hA, 4'hC, 4'hE: top = s.capture_value;
			default: top = CNT_MAX;
		endcase
	end

	// timer tick from the selected source
	logic tick;
	always_comb
	begin
		case (s.timer_control_b[CB_CS +: 3])
			CS_STOP: tick = 1'b0;
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = &s.pre[2:0];
			CS_DIV64: tick = &s.pre[5:0];
			CS_DIV256: tick = &s.pre[7:0];
			CS_DIV1024: tick = &s.pre[9:0];
			CS_EXT_FALL: tick = s.ext_prev & !ext_lvl;
			CS_EXT_RISE: tick = !s.ext_prev & ext_lvl;
			default: tick = 1'b0;
		endcase
	end

	// counter events this tick
	logic at_top;
	logic wrap;
	logic turn_down;
	logic turn_up;
	assign at_top = (s.count_value == top);
	assign wrap = tick & !dual & (at_top | (s.count_value == CNT_MAX));
	assign turn_down = tick & dual & s.up & at_top;
	assign turn_up = tick & dual & !s.up & (s.count_value == CNT_BOTTOM);

	// per channel match and next output level
	logic [1:0] match;
	logic [1:0] out_nx;
	logic [1:0][1:0] com;
	assign com[0] = s.timer_control_a[CA_COM_A +: 2];
	assign com[1] = s.timer_control_a[CA_COM_B +: 2];
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_ch
			// equality with the active compare value, checked on each timer tick
			assign match[ch] = tick & (s.count_value == s.cmp[ch]);
			// waveform action for this channel
			always_comb
			begin
				out_nx[ch] = s.cout[ch];
				if (ch == 0 && pwm && ocra_top)
					out_nx[ch] = s.cout[ch];
				else if (!pwm)
				begin
					// non-pwm: toggle, clear or set on match
					if (match[ch])
					begin
						case (com[ch])
							2'h1: out_nx[ch] = !s.cout[ch];
							2'h2: out_nx[ch] = 1'b0;
							2'h3: out_nx[ch] = 1'b1;
							default: out_nx[ch] = s.cout[ch];
						endcase
					end
				end
				else if (com[ch][1])
				begin
					// pwm: up-count match ends the pulse, down-count match or bottom starts it
					if (match[ch])
						out_nx[ch] = com[ch][0] ^ (dual ? !s.up : 1'b0);
					else if (wrap | turn_up)
						out_nx[ch] = !com[ch][0];
				end
			end
		end
	endgenerate

	// bus decode
	logic acc;
	logic wr;
	logic rd;
	logic [5:0] idx;
	logic [7:0] wd;
	assign acc = CYC_I & STB_I & !s.ack;
	assign wr = acc & WE_I & SEL_I[0];
	assign rd = acc & !WE_I;
	assign idx = ADR_I[7:2];
	assign wd = DAT_I[7:0];

	// capture event qualified by edge, held off while capture defines top
	logic cap_evt;
	logic cap_edge;
	assign cap_edge = s.timer_control_b[CB_CAP_EDGE] ? (!s.cap_prev & cap_lvl)
		: (s.cap_prev & !cap_lvl);
	assign cap_evt = cap_edge & !icr_top;

	// compare buffer update point: immediate, or at bottom/top in pwm
	logic cmp_load;
	assign cmp_load = !pwm | wrap | (mode inside {4'h8, 4'h9} ? turn_up : turn_down);

	// next state
	always_comb
	begin
		next_s = s;
		next_s.pre = s.pre + 1'b1;
		next_s.ext_prev = ext_lvl;
		next_s.cap_prev = cap_lvl;
		next_s.ack = acc;

		// counting
		if (wrap)
			next_s.count_value = CNT_BOTTOM;
		else if (turn_down)
		begin
			next_s.up = 1'b0;
			next_s.count_value = s.count_value - 16'h0001;
		end
		else if (turn_up)
		begin
			next_s.up = 1'b1;
			next_s.count_value = s.count_value + 16'h0001;
		end
		else if (tick)
			next_s.count_value = s.up ? s.count_value + 16'h0001 : s.count_value - 16'h0001;
		if (!dual)
			next_s.up = 1'b1;

		// compare buffers reach the comparator
		for (int i = 0; i < 2; i++)
		begin
			if (cmp_load)
				next_s.cmp[i] = s.cmp_buf[i];
		end

		// capture copies the count
		if (cap_evt)
			next_s.capture_value = s.count_value;

		// read side effects and data
		next_s.rdata = 8'h00;
		if (rd)
		begin
			case (idx)
				IDX_CTRL_A: next_s.rdata = s.timer_control_a;
				IDX_CTRL_B: next_s.rdata = s.timer_control_b;
				IDX_CNT_LO:
				begin
					next_s.rdata = s.count_value[7:0];
					next_s.hold = s.count_value[15:8];
				end
				IDX_CNT_HI, IDX_CAP_HI: next_s.rdata = s.hold;
				IDX_CMPA_LO: next_s.rdata = s.cmp_buf[0][7:0];
				IDX_CMPA_HI: next_s.rdata = s.cmp_buf[0][15:8];
				IDX_CMPB_LO: next_s.rdata = s.cmp_buf[1][7:0];
				IDX_CMPB_HI: next_s.rdata = s.cmp_buf[1][15:8];
				IDX_CAP_LO:
				begin
					next_s.rdata = s.capture_value[7:0];
					next_s.hold = s.capture_value[15:8];
				end
				IDX_FLAG: next_s.rdata = {4'h0, s.timer_flag_reg};
				IDX_MASK: next_s.rdata = {4'h0, s.timer_mask_reg};
				default: next_s.rdata = 8'h00; // unmapped reads zero
			endcase
		end

		// writes; the count write comes last so it beats counting
		if (wr)
		begin
			case (idx)
				IDX_CTRL_A: next_s.timer_control_a = wd;
				IDX_CTRL_B: next_s.timer_control_b = wd;
				IDX_CNT_HI, IDX_CMPA_HI, IDX_CMPB_HI, IDX_CAP_HI:
					next_s.hold = wd;
				IDX_CNT_LO: next_s.count_value = {s.hold, wd};
				IDX_CMPA_LO: next_s.cmp_buf[0] = {s.hold, wd};
				IDX_CMPB_LO: next_s.cmp_buf[1] = {s.hold, wd};
				IDX_CAP_LO:
				begin
					// writable only while it defines top
					if (icr_top)
						next_s.capture_value = {s.hold, wd};
				end
				IDX_FLAG: next_s.timer_flag_reg = s.timer_flag_reg & ~wd[3:0];
				IDX_MASK: next_s.timer_mask_reg = wd[3:0];
				default: next_s.hold = s.hold; // unmapped writes ignored
			endcase
		end

		// flag sets win over a same-cycle clear
		if (wrap | turn_up)
			next_s.timer_flag_reg[FL_OVF] = 1'b1;
		if (match[0])
			next_s.timer_flag_reg[FL_CMP_A] = 1'b1;
		if (match[1])
			next_s.timer_flag_reg[FL_CMP_B] = 1'b1;
		if (cap_evt | (icr_top & at_top & tick))
			next_s.timer_flag_reg[FL_CAP] = 1'b1;

		// output pins
		next_s.cout = out_nx;

		// limit status follows the new count
		next_s.bottom = (next_s.count_value == CNT_BOTTOM);
		next_s.max = (next_s.count_value == CNT_MAX);
	end

	// register the state; hold clears so a lone low write gives zero above
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			s <= '0;
			s.timer_control_a <= RST_CTRL;
			s.timer_control_b <= RST_CTRL;
			s.hold <= RST_HOLD;
			s.count_value <= RST_WORD;
			s.up <= 1'b1;
			s.timer_flag_reg <= RST_FLAG;
			s.timer_mask_reg <= RST_MASK;
			s.bottom <= 1'b1;
		end
		else
			s <= next_s;
	end

	// outputs
	assign DAT_O = {24'h000000, s.rdata};
	assign ACK_O = s.ack;
	assign COMPARE_OUT_A = s.cout[0];
	assign COMPARE_OUT_B = s.cout[1];
	assign AT_BOTTOM = s.bottom;
	assign AT_MAX = s.max;
	assign IRQ_REQ = s.timer_flag_reg & s.timer_mask_reg;
endmodule // tmr_timer16
`default_nettype wire

// ==== tb/tmr_host.sv ====
// bus master model standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module tmr_host
(
	input wire logic CLK,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	input wire logic [31:0] rdat,
	input wire logic ack
);
	// bus idle at time zero
	initial
	begin
		cyc = 1'h0;
		stb = 1'h0;
		we = 1'h0;
		adr = 8'hFF;
		sel = 4'hF;
		dat = 32'h0;
	end
	// one byte cycle held until ack is sampled; stale lines are scrambled after release
	task automatic acc(input logic w, input logic [5:0] i, input logic [7:0] d,
		output logic [7:0] q);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		sel <= 4'h1;
		adr <= {i, 2'h0};
		dat <= {24'h0, d};
		do
			@(posedge CLK);
		while (ack !== 1'h1);
		q = rdat[7:0];
		cyc <= 1'h0;
		stb <= 1'h0;
		adr <= ~adr;
		dat <= ~dat;
		@(posedge CLK);
	endtask
	// upper byte first; a single caller process keeps the pair unbroken
	task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
		logic [7:0] x;
		acc(1'h1, lo + 6'h01, v[15:8], x);
		acc(1'h1, lo, v[7:0], x);
	endtask
	// low byte first so the upper byte is frozen in the hold
	task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
		logic [7:0] l;
		logic [7:0] h;
		acc(1'h0, lo, 8'h00, l);
		acc(1'h0, lo + 6'h01, 8'h00, h);
		v = {h, l};
	endtask
endmodule // tmr_host
`default_nettype wire

// ==== tb/tmr_timer16_chk.sv ====
// assertions on the timer's bus and status ports
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16_chk
	import tmr_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [ADDR_W-1:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	input wire logic [31:0] DAT_O,
	input wire logic ACK_O,
	input wire logic AT_BOTTOM,
	input wire logic AT_MAX,
	input wire logic [3:0] IRQ_REQ
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	// shadow of software settings; hold known only until hardware reloads it
	typedef struct packed {
		logic [3:0] mask;
		logic [2:0] cs;
		logic [7:0] hold;
		logic hv;
		logic rhi;
	} tmr_shd_t;
	tmr_shd_t s;
	tmr_shd_t next_s;
	logic take;
	logic [5:0] idx;
	assign take = CYC_I && STB_I && !ACK_O;
	assign idx = ADR_I[7:2];
	// next shadow from the request taken at this edge
	always_comb
	begin
		next_s = s;
		next_s.rhi = take && !WE_I && (idx == IDX_CNT_HI || idx == IDX_CAP_HI);
		if (take && !WE_I && (idx == IDX_CNT_LO || idx == IDX_CAP_LO))
			next_s.hv = 1'h0;
		if (take && WE_I && SEL_I[0])
		begin
			if (idx == IDX_MASK)
				next_s.mask = DAT_I[3:0];
			if (idx == IDX_CTRL_B)
				next_s.cs = DAT_I[2:0];
			if (idx inside {IDX_CNT_HI, IDX_CMPA_HI, IDX_CMPB_HI, IDX_CAP_HI})
				next_s.hold = DAT_I[7:0];
			if (idx inside {IDX_CNT_HI, IDX_CMPA_HI, IDX_CMPB_HI, IDX_CAP_HI})
				next_s.hv = 1'h1;
		end
	end
	// shadow register; hold is zero and known after reset
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			s <= '{RST_MASK, CS_STOP, RST_HOLD, 1'h1, 1'h0};
		else
			s <= next_s;
	end
	property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_answer; take |=> ACK_O; endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("no ack");
	property p_ack_cause; ACK_O |-> $past(take); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	property p_rd_width; ACK_O |-> DAT_O[31:8] == 24'h0; endproperty
	a_rd_width: assert property (p_rd_width) else $error("wide read data");
	property p_hold; ACK_O && s.rhi && s.hv |-> DAT_O[7:0] == s.hold; endproperty
	a_hold: assert property (p_hold) else $error("hold byte wrong");
	property p_bot_max; !(AT_BOTTOM && AT_MAX); endproperty
	a_bot_max: assert property (p_bot_max) else $error("bottom and max");
	// a mask change may take one cycle to reach the request lines
	property p_irq_gate; (IRQ_REQ & ~s.mask & ~$past(s.mask)) == 4'h0; endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("unmasked request");
	property p_stopped;
		s.cs == CS_STOP && !CYC_I && !$past(CYC_I) && !$past(CYC_I, 2)
			|=> $stable(AT_BOTTOM) && $stable(AT_MAX);
	endproperty
	a_stopped: assert property (p_stopped) else $error("stopped count moved");
	// a count write of zero must land even in a cycle where the counter ticks
	property p_cnt_wr;
		take && WE_I && SEL_I[0] && idx == IDX_CNT_LO && s.hv
			&& {s.hold, DAT_I[7:0]} == CNT_BOTTOM |=> AT_BOTTOM;
	endproperty
	a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost");
	c_hold: cover property (ACK_O && s.rhi && s.hv);
	c_cap: cover property (IRQ_REQ[FL_CAP]);
	c_wrap: cover property (AT_MAX ##1 AT_BOTTOM);
endmodule // tmr_timer16_chk
bind tmr_timer16 tmr_timer16_chk #(.ADDR_W(ADDR_W)) u_chk (.CLK(CLK), .RESET_N(RESET_N),
	.CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
	.DAT_O(DAT_O), .ACK_O(ACK_O), .AT_BOTTOM(AT_BOTTOM), .AT_MAX(AT_MAX), .IRQ_REQ(IRQ_REQ));
`default_nettype wire

// ==== tb/test_tmr_timer16.sv ====
// self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`default_nettype none
module test_tmr_timer16
	import tmr_pkg::*;
;
	logic CLK = 1'h0;
	logic RESET_N = 1'h0;
	logic ext = 1'h0;
	logic cap = 1'h0;
	logic cmpi = 1'h0;
	wire logic cyc, stb, we, ack, co_a, co_b, bot, mx;
	wire logic [7:0] adr;
	wire logic [3:0] sel, irq;
	wire logic [31:0] dw, dr;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [7:0] q;
	logic [15:0] w;
	tmr_timer16 DUT (.CLK(CLK), .RESET_N(RESET_N), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(sel), .DAT_I(dw), .DAT_O(dr), .ACK_O(ack),
		.EXT_COUNT_PIN(ext), .CAPTURE_PIN(cap), .COMPARATOR_IN(cmpi),
		.COMPARE_OUT_A(co_a), .COMPARE_OUT_B(co_b), .AT_BOTTOM(bot), .AT_MAX(mx),
		.IRQ_REQ(irq));
	tmr_host host (.CLK(CLK), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.dat(dw), .rdat(dr), .ack(ack));
	initial
	begin
		forever #4 CLK = ~CLK;
	end
	// hang guard
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			tally_and_finish;
		end
	end
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task wr(input logic [5:0] i, input logic [7:0] d);
		host.acc(1'h1, i, d, q);
	endtask
	task rd(input logic [5:0] i);
		host.acc(1'h0, i, 8'h00, q);
	endtask
	// bounded wait for one request line
	task wirq(input int b, input int n);
		repeat (n)
		begin
			@(posedge CLK);
			if (irq[b] === 1'h1)
				break;
		end
	endtask
	task t_lone;
		chk("bot0", bot, 1);
		chk("irq0", irq, 0);
		wr(IDX_CNT_LO, 8'h34);
		host.rd16(IDX_CNT_LO, w);
		chk("lone", w, 16'h0034);
		chk("bot1", bot, 0);
	endtask
	// compare reads leave the shared hold alone
	task t_shared;
		wr(IDX_CMPA_HI, 8'h12);
		rd(IDX_CNT_HI);
		chk("hihold", q, 8'h12);
		wr(IDX_CNT_LO, 8'h56);
		host.rd16(IDX_CNT_LO, w);
		chk("shared", w, 16'h1256);
		host.wr16(IDX_CMPA_LO, 16'hABCD);
		rd(IDX_CNT_LO);
		rd(IDX_CMPA_LO);
		chk("cmplo", q, 8'hCD);
		rd(IDX_CMPA_HI);
		chk("cmphi", q, 8'hAB);
		rd(IDX_CNT_HI);
		chk("keep", q, 8'h12);
		wr(IDX_CTRL_A, 8'hF0);
		rd(IDX_CTRL_A);
		chk("ctla", q, 8'hF0);
		wr(IDX_CTRL_A, 8'h00);
		wr(6'h20, 8'h5A);
		rd(6'h20);
		chk("unmap", q, 8'h00);
	endtask
	task t_compare;
		host.wr16(IDX_CNT_LO, 16'h0000);
		host.wr16(IDX_CMPA_LO, 16'h0020);
		wr(IDX_FLAG, 8'h0F);
		wr(IDX_MASK, 8'h02);
		wr(IDX_CTRL_A, 8'h40);
		wr(IDX_CTRL_B, {5'h00, CS_DIV1});
		chk("early", irq[FL_CMP_A], 0);
		wirq(FL_CMP_A, 100);
		chk("match", irq[FL_CMP_A], 1);
		chk("outa", co_a, 1);
		chk("outb", co_b, 0);
		host.wr16(IDX_CNT_LO, 16'h0000);
		wr(IDX_CTRL_B, 8'h00);
		wr(IDX_CTRL_A, 8'h00);
		wr(IDX_MASK, 8'h00);
		chk("masked", irq, 0);
		rd(IDX_FLAG);
		chk("flag", q[FL_CMP_A], 1);
		wr(IDX_FLAG, 8'h02);
		rd(IDX_FLAG);
		chk("flagclr", q[FL_CMP_A], 0);
	endtask
	// compare A as top: the count wraps long before all ones
	task t_top;
		host.wr16(IDX_CMPA_LO, 16'h0010);
		host.wr16(IDX_CNT_LO, 16'h0000);
		wr(IDX_FLAG, 8'h0F);
		wr(IDX_MASK, 8'h01);
		wr(IDX_CTRL_B, {3'h0, 2'h1, CS_DIV1});
		wirq(FL_OVF, 100);
		chk("top", irq[FL_OVF], 1);
		wr(IDX_CTRL_B, 8'h00);
		wr(IDX_MASK, 8'h00);
	endtask
	// three pin pulses, counted on the chosen edge
	task t_ext(input logic [2:0] c);
		host.wr16(IDX_CNT_LO, 16'h0000);
		wr(IDX_CTRL_B, {5'h00, c});
		repeat (3)
		begin
			repeat (8) @(posedge CLK);
			ext <= 1'h1;
			repeat (8) @(posedge CLK);
			ext <= 1'h0;
		end
		repeat (8) @(posedge CLK);
		wr(IDX_CTRL_B, 8'h00);
		host.rd16(IDX_CNT_LO, w);
		chk("ext", w, 16'h0003);
	endtask
	task t_wrap;
		host.wr16(IDX_CNT_LO, 16'hFFFF);
		chk("max1", mx, 1);
		host.rd16(IDX_CNT_LO, w);
		chk("full", w, 16'hFFFF);
		wr(IDX_FLAG, 8'h0F);
		wr(IDX_MASK, 8'h01);
		wr(IDX_CTRL_B, {5'h00, CS_DIV1024});
		wirq(FL_OVF, 1100);
		chk("ovf", irq[FL_OVF], 1);
		wr(IDX_CTRL_B, 8'h00);
		chk("bot", bot, 1);
		chk("max0", mx, 0);
	endtask
	// capture through the noise filter on a rising edge
	task t_capture;
		host.wr16(IDX_CNT_LO, 16'h0777);
		wr(IDX_CTRL_B, 8'hC0);
		wr(IDX_FLAG, 8'h0F);
		wr(IDX_MASK, 8'h08);
		cap <= 1'h1;
		wirq(FL_CAP, 30);
		chk("capflag", irq[FL_CAP], 1);
		host.rd16(IDX_CAP_LO, w);
		chk("capval", w, 16'h0777);
		rd(IDX_CTRL_B);
		chk("ctlb", q, 8'hC0);
		// comparator as source, rising edge, no filter; the switch itself only sees a fall
		host.wr16(IDX_CNT_LO, 16'h0123);
		wr(IDX_CTRL_B, 8'h60);
		wr(IDX_FLAG, 8'h0F);
		cmpi <= 1'h1;
		wirq(FL_CAP, 30);
		chk("cmpflag", irq[FL_CAP], 1);
		host.rd16(IDX_CAP_LO, w);
		chk("cmpval", w, 16'h0123);
	endtask
	initial
	begin
		repeat (12) @(posedge CLK);
		RESET_N <= 1'h1;
		@(posedge CLK);
		t_lone;
		t_shared;
		t_compare;
		t_top;
		t_ext(CS_EXT_RISE);
		t_ext(CS_EXT_FALL);
		t_wrap;
		t_capture;
		tally_and_finish;
	end
endmodule // test_tmr_timer16
`default_nettype wire
